// ---- hdl/asr_pkg.sv ----
// Purpose: constants for the asynchronous byte-wide SRAM access controller
// Assumes: 125 MHz system clock, slowest speed grade timings
// Notes: all times in ns, cycle counts derived from them
package asr_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_WIDTH = 17;
  localparam int DATA_WIDTH = 8;
  // Slowest grade figures so any grade part is served
  localparam int ADDR_SETUP_TO_WRITE_END_NS = 10;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 8;
  localparam int WRITE_RELEASE_TO_OUTPUT_NS = 3;
  localparam int WRITE_PULSE_NS = 10;
  localparam int READ_ACCESS_NS = 15;
  localparam int OUTPUT_RELEASE_NS = 7;
  localparam int DESELECT_TO_STANDBY_NS = 15;
  localparam int ADDR_SETUP_TO_WRITE_START_NS = 0;
  localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
  // Least times round up, never below one cycle
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WRITE_LOW_CYCLES = ceil_cycles(WRITE_PULSE_NS);
  localparam int READ_WAIT_CYCLES = ceil_cycles(READ_ACCESS_NS);
  localparam int TURNAROUND_CYCLES = ceil_cycles(OUTPUT_RELEASE_NS);
  localparam int STANDBY_CYCLES = ceil_cycles(DESELECT_TO_STANDBY_NS);
  localparam int CNT_WIDTH = 4;
  typedef enum logic [2:0] {
    ASR_IDLE, ASR_SETUP, ASR_WRITE, ASR_WEND, ASR_READ, ASR_TURN
  } asr_state_type;
endpackage

// ---- hdl/asr_timer.sv ----
// Purpose: down counter timing one strobe phase
// Assumes: load has priority over counting
// Notes: done is high when the count is zero
`timescale 1ns/10ps
`default_nettype none
module asr_timer
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic load,
  input wire logic [CNT_WIDTH-1:0] loadValue,
  output logic done
);
  typedef struct packed {
    logic [CNT_WIDTH-1:0] count;
  } asr_timer_type;
  asr_timer_type r;
  asr_timer_type next_r;
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.count = loadValue;
    end else if (r.count != '0) begin
      next_r.count = r.count - 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign done = (r.count == '0);
endmodule
`default_nettype wire

// ---- hdl/asr_standby.sv ----
// Purpose: tracks whether the memory has reached standby after deselect
// Assumes: chip select sampled as driven by the controller
// Notes: standby reported once the longest power-down time has passed
`timescale 1ns/10ps
`default_nettype none
module asr_standby
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Chip select as driven
  input wire logic chipSelect_n,
  output logic standby
);
  typedef struct packed {
    logic [CNT_WIDTH-1:0] count;
    logic standby;
  } asr_stby_type;
  asr_stby_type r;
  asr_stby_type next_r;
  always_comb begin
    next_r = r;
    if (!chipSelect_n) begin
      next_r.count = '0;
      next_r.standby = 1'b0;
    end else if (r.count == CNT_WIDTH'(STANDBY_CYCLES - 1)) begin
      next_r.standby = 1'b1;
    end else begin
      next_r.count = r.count + 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '{count: '0, standby: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign standby = r.standby;
endmodule
`default_nettype wire

// ---- hdl/asr_ctrl.sv ----
// Purpose: controller driving an asynchronous 128K x 8 static RAM
// Assumes: one request at a time, user holds request until ready
// Notes: write is strobe controlled by write enable, chip select brackets it
// Operation
// R1: Memory writes only while chip select and write enable are both low.
// R2: Write ends when chip select or write enable rises first.
// R3: Time data setup and hold from the strobe edge ending the write.
// R4: Hold address stable long enough before the write ends.
// R5: Address may change right after the write ends, zero hold.
// R6: Address valid no later than the start of the write overlap.
// R7: Drive write data valid long enough before the write ends.
// R8: Keep write data valid until the write-ending edge.
// R9: Memory enters standby within power-down time after deselect.
// R10: Simultaneous rise of select and write enable leaves outputs floating.
// R11: Write cycle with output enable low spans release plus data setup.
// R12: Controller never drives data lines while the memory drives them.
// R13: Write enable stays high for the whole read cycle.
// R14: Address valid before or with chip select falling on reads.
// R15: Select and output enable low, write enable high, reads a byte.
// R16: Data lines float when deselected, disabled, or writing.
// R17: Memory stores data lines at addressed location during write.
// R18: Selected with both enables high keeps data lines floating.
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_WIDTH-1:0] reqAddr,
  input wire logic [DATA_WIDTH-1:0] reqData,
  output logic reqReady,
  // User answer
  output logic rspValid,
  output logic [DATA_WIDTH-1:0] rspData,
  output logic memStandby,
  // Memory pins
  output logic chipSelect_n,
  output logic outputEnable_n,
  output logic writeEnable_n,
  output logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] dataLinesIn,
  output logic [DATA_WIDTH-1:0] dataLinesOut,
  output logic dataLinesOe
);
  typedef struct packed {
    asr_state_type state;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic drive;
    logic rspValid;
    logic [DATA_WIDTH-1:0] rspData;
  } asr_ctrl_type;

  asr_ctrl_type r;
  asr_ctrl_type next_r;
  logic timerLoad;
  logic [CNT_WIDTH-1:0] timerValue;
  logic timerDone;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe and driver levels held in each state
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic drive;
  } asr_pins_type;
  asr_pins_type pinsNext;
  asr_pins_type pinsNow;
  logic memDrivesNow;
  logic writeOverlapNow;

  // R12 R13 one table for all states, so no branch leaves a strobe stale
  function automatic asr_pins_type pins_for(input asr_state_type s);
    asr_pins_type p;
    p = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, drive: 1'b0};
    unique case (s)
      ASR_IDLE: begin
        p.cs_n = 1'b1;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.drive = 1'b0;
      end
      ASR_SETUP: begin
        p.cs_n = 1'b0;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.drive = 1'b0;
      end
      ASR_WRITE: begin
        p.cs_n = 1'b0;
        p.oe_n = 1'b1;
        p.we_n = 1'b0;
        p.drive = 1'b1;
      end
      ASR_WEND: begin
        p.cs_n = 1'b0;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.drive = 1'b1;
      end
      ASR_READ: begin
        p.cs_n = 1'b0;
        p.oe_n = 1'b0;
        p.we_n = 1'b1;
        p.drive = 1'b0;
      end
      ASR_TURN: begin
        p.cs_n = 1'b1;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.drive = 1'b0;
      end
      default: begin
        p.cs_n = 1'b1;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.drive = 1'b0;
      end
    endcase
    return p;
  endfunction

  // Memory answers on the data lines only in read mode
  function automatic logic mem_drives(input logic cs_n, input logic oe_n,
    input logic we_n);
    return !cs_n && !oe_n && we_n;
  endfunction

  // Internal write runs for the overlap of both strobes
  function automatic logic write_overlap(input logic cs_n,
    input logic we_n);
    return !cs_n && !we_n;
  endfunction

  // Phase lengths in whole cycles, rounded up from the slowest grade
  function automatic logic [CNT_WIDTH-1:0] phase_cycles(
    input asr_state_type s);
    logic [CNT_WIDTH-1:0] n;
    n = '0;
    unique case (s)
      ASR_WRITE: n = CNT_WIDTH'(WRITE_LOW_CYCLES);
      ASR_READ: n = CNT_WIDTH'(READ_WAIT_CYCLES);
      ASR_TURN: n = CNT_WIDTH'(TURNAROUND_CYCLES);
      default: n = '0;
    endcase
    return n;
  endfunction

  // Requests are looked at only once the bus is fully released
  function automatic logic accepts(input asr_state_type s);
    return s == ASR_IDLE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  asr_timer u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  // R9 standby tracking
  asr_standby u_standby (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .chipSelect_n(r.cs_n),
    .standby(memStandby)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rspValid = 1'b0;
    timerLoad = 1'b0;
    timerValue = '0;
    unique case (r.state)
      ASR_IDLE: begin
        if (reqValid) begin
          // R6 address and select set up before write enable falls
          // R14 address valid with chip select falling
          next_r.addr = reqAddr;
          next_r.cs_n = 1'b0;
          // R13 write enable high through reads
          next_r.we_n = 1'b1;
          if (reqWrite) begin
            // Output enable held high, so no turnaround wait is needed
            next_r.oe_n = 1'b1;
            next_r.wdata = reqData;
            next_r.state = ASR_SETUP;
          end else begin
            next_r.oe_n = 1'b0;
            timerLoad = 1'b1;
            timerValue = phase_cycles(ASR_READ);
            next_r.state = ASR_READ;
          end
        end
      end
      ASR_SETUP: begin
        // R12 drive only once memory outputs are disabled
        // R1 overlap of select and write enable starts the write
        next_r.drive = 1'b1;
        next_r.we_n = 1'b0;
        timerLoad = 1'b1;
        // R4 R7 R11 pulse covers address and data setup to write end
        timerValue = phase_cycles(ASR_WRITE);
        next_r.state = ASR_WRITE;
      end
      ASR_WRITE: begin
        if (timerDone) begin
          // R2 R3 write enable rise ends the write, select stays low
          next_r.we_n = 1'b1;
          next_r.state = ASR_WEND;
        end
      end
      ASR_WEND: begin
        // R5 R8 data and address released one cycle after the end
        // R10 select raised after write enable, not together
        next_r.drive = 1'b0;
        next_r.cs_n = 1'b1;
        // Leave only once the strobe overlap is really over
        if (!writeOverlapNow) begin
          next_r.state = ASR_IDLE;
        end
      end
      ASR_READ: begin
        if (timerDone) begin
          // R15 byte sampled after access time
          next_r.rspData = dataLinesIn;
          next_r.rspValid = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.cs_n = 1'b1;
          timerLoad = 1'b1;
          timerValue = phase_cycles(ASR_TURN);
          next_r.state = ASR_TURN;
        end
      end
      ASR_TURN: begin
        // R12 R16 wait for memory to float before a write may drive
        if (timerDone) begin
          next_r.state = ASR_IDLE;
        end
      end
      default: begin
        next_r.state = ASR_IDLE;
      end
    endcase
    // Pins follow the state entered; the branches above only pick it
    pinsNext = pins_for(next_r.state);
    next_r.cs_n = pinsNext.cs_n;
    next_r.oe_n = pinsNext.oe_n;
    next_r.we_n = pinsNext.we_n;
    next_r.drive = pinsNext.drive;
    // R12 interlock: drivers stay off whenever the memory may answer
    if (mem_drives(next_r.cs_n, next_r.oe_n, next_r.we_n)) begin
      next_r.drive = 1'b0;
    end
    // R5 R6 R8 address and data move only while deselected
    if (!r.cs_n) begin
      next_r.addr = r.addr;
      next_r.wdata = r.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '{state: ASR_IDLE, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
             addr: '0, wdata: '0, drive: 1'b0, rspValid: 1'b0,
             rspData: '0};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reqReady = accepts(r.state);
  assign rspValid = r.rspValid;
  assign rspData = r.rspData;
  assign chipSelect_n = r.cs_n;
  assign outputEnable_n = r.oe_n;
  assign writeEnable_n = r.we_n;
  assign addr = r.addr;

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin levels as the memory sees them
  assign pinsNow = {r.cs_n, r.oe_n, r.we_n, r.drive};
  assign memDrivesNow = mem_drives(pinsNow.cs_n, pinsNow.oe_n, pinsNow.we_n);
  assign writeOverlapNow = write_overlap(pinsNow.cs_n, pinsNow.we_n);
  // R17 each data line carries its bit of the held write byte
  for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_data
    assign dataLinesOut[i] = r.wdata[i];
  end
  // R12 drivers dropped at once if the memory could be answering
  assign dataLinesOe = pinsNow.drive && !memDrivesNow;
endmodule
`default_nettype wire

// ---- testbench/asr_mem_model.sv ----
// Purpose: behavioural byte-wide static RAM
// Assumes: no pin delays
// Notes: released lines show the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module asr_mem_model
  import asr_pkg::*;
(
  // Strobes
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic writeEnable_n,
  // Address and data
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] dataIn,
  output logic [DATA_WIDTH-1:0] dataOut,
  output logic driving
);
  logic [DATA_WIDTH-1:0] mem [int];
  logic [DATA_WIDTH-1:0] last = 8'h00;
  logic armed = 1'b0;
  wire logic wrEnd = chipSelect_n | writeEnable_n;
  always @(negedge wrEnd) armed = 1'b1;
  always @(posedge wrEnd) begin
    if (armed) mem[addr] = dataIn;
    armed = 1'b0;
  end
  assign driving = !chipSelect_n && !outputEnable_n && writeEnable_n;
  always @* begin
    if (driving) last = mem.exists(addr) ? mem[addr] : 8'h00;
  end
  assign dataOut = driving ? last : ~last;
endmodule
`default_nettype wire

// ---- testbench/asr_ctrl_assertions.sv ----
// Purpose: port checks of the RAM access controller
// Assumes: slowest grade cycle figures
// Notes: bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl_checker
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request side
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqReady,
  input wire logic rspValid,
  // Memory pins
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic writeEnable_n,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] dataLinesOut,
  input wire logic dataLinesOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire logic takeRd = reqValid && reqReady && !reqWrite;
  ////////////////////////////////////////
  no_contention_a: assert property (!outputEnable_n |-> !dataLinesOe)
    else $error("data lines driven while output enabled");
  read_we_high_a: assert property (takeRd |=> writeEnable_n [*4])
    else $error("write enable low in read cycle");
  addr_held_a: assert property (
    !chipSelect_n && !$past(chipSelect_n) |-> $stable(addr))
    else $error("address moved while selected");
  we_in_cs_a: assert property (
    !writeEnable_n |-> !chipSelect_n && !$past(chipSelect_n))
    else $error("write strobe outside select");
  data_held_a: assert property (
    !writeEnable_n |=> $stable(dataLinesOut) && dataLinesOe)
    else $error("write data not held to write end");
  we_pulse_a: assert property (
    $fell(writeEnable_n) |-> !writeEnable_n [*3] ##1 writeEnable_n)
    else $error("write pulse length wrong");
  cs_after_we_a: assert property (
    $rose(writeEnable_n) |-> !chipSelect_n ##1 chipSelect_n)
    else $error("select not released after write strobe");
  read_answer_a: assert property (takeRd |-> ##4 rspValid)
    else $error("read answer late");
  cover property (takeRd);
  cover property ($fell(writeEnable_n));
  cover property (rspValid ##2 reqValid && reqReady);
endmodule
bind asr_ctrl asr_ctrl_checker i_asr_ctrl_checker (.clk_sys, .nrst,
  .reqValid, .reqWrite, .reqReady, .rspValid, .chipSelect_n,
  .outputEnable_n, .writeEnable_n, .addr, .dataLinesOut, .dataLinesOe);
`default_nettype wire

// ---- testbench/asr_ctrl_tb.sv ----
// Purpose: self-checking bench of the RAM access controller
// Assumes: memory model answers at once
// Notes: reference contents in an associative array
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl_tb
  import asr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [ADDR_WIDTH-1:0] reqAddr = '0;
  logic [DATA_WIDTH-1:0] reqData = '0;
  logic reqReady, rspValid, memStandby, chipSelect_n, outputEnable_n;
  logic writeEnable_n, dataLinesOe, memDrive;
  logic [ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0] rspData, dataLinesOut, memOut, busLevel;
  logic [DATA_WIDTH-1:0] refMem [int];
  logic [31:0] seed = 32'h20a1;
  int miscompares = 0;
  int num_checks = 0;
  assign busLevel = (dataLinesOe && !memDrive) ? dataLinesOut : memOut;
  always #4 clk_sys = ~clk_sys;
  asr_ctrl i_asr_ctrl (.clk_sys, .nrst, .reqValid, .reqWrite, .reqAddr,
    .reqData, .reqReady, .rspValid, .rspData, .memStandby, .chipSelect_n,
    .outputEnable_n, .writeEnable_n, .addr, .dataLinesIn(busLevel),
    .dataLinesOut, .dataLinesOe);
  asr_mem_model i_asr_mem_model (.chipSelect_n, .outputEnable_n,
    .writeEnable_n, .addr, .dataIn(busLevel), .dataOut(memOut),
    .driving(memDrive));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wait_for(ref logic sig);
    int n;
    for (n = 0; n < 20 && sig !== 1'b1; n++) @(negedge clk_sys);
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic do_req(input logic wr, input logic [ADDR_WIDTH-1:0] a);
    @(negedge clk_sys);
    seed = lfsr(seed);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = seed[7:0];
    wait_for(reqReady);
    @(negedge clk_sys);
    reqValid = 1'b0;
    if (wr) begin
      refMem[a] = reqData;
    end else begin
      wait_for(rspValid);
      check("read byte", refMem[a], rspData);
      check("standby", 8'h00, {7'h0, memStandby});
    end
  endtask
  initial begin
    logic [ADDR_WIDTH-1:0] a;
    logic [ADDR_WIDTH-1:0] used [$];
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      if (i < 4 || seed[9] === 1'b1) begin
        a = (i == 0) ? '0 : (i == 1) ? '1 : seed[21:5];
        used.push_back(a);
        do_req(1'b1, a);
      end else begin
        do_req(1'b0, used[seed[7:0] % used.size()]);
      end
    end
    $display("test mixed traffic done");
    repeat (8) @(negedge clk_sys);
    check("standby", 8'h01, {7'h0, memStandby});
    nrst = 1'b0;
    @(negedge clk_sys);
    check("chip select", 8'h01, {7'h0, chipSelect_n});
    nrst = 1'b1;
    do_req(1'b0, used[1]);
    $display("test standby and reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
